/* rtl/lap_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module lap_regs
  import lap_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  input  wire logic       fifo_overflow_evt,
  input  wire logic       fifo_underflow_evt,
  input  wire logic       link_valid,
  input  wire logic       video_disabled,
  input  wire logic       local_gp_input0,
  input  wire logic       filtered_backchannel,
  output var  logic       audio_rising_edge,
  output var  logic [1:0] pclk_external_sel,
  output var  logic       rx_lock,
  output var  logic       backchannel_out,
  output var  logic [1:0] link_input_mode
);

  logic [2:0] pin_s;
  logic       scl_s;
  logic       sda_s;
  logic       gp0_s;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  lap_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic       first_byte_reg;
  lap_wr_t    wr_reg;
  lap_audio_t audio_reg;
  logic [1:0] pclk_copy_reg;
  lap_dual_t  dual_reg;
  logic       err_clear;
  logic [7:0] rd_data;

  // Bus pins pass inverted, so the synchroniser's reset state reads as an idle, pulled-up bus.
  lap_sync #(.W(3)) lap_sync_inst (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .din      ({~scl_in, ~sda_in, local_gp_input0}),
    .dout     (pin_s)
  );

  assign scl_s = ~pin_s[2];
  assign sda_s = ~pin_s[1];
  assign gp0_s = pin_s[0];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Read view of the map; port 1 wins when both selects are set.
  function automatic logic [7:0] reg_read(input logic [7:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    unique case (ofs)
      LAP_AUDIO_OFS: begin
        v[LAP_AUD_OVF_BIT]  = audio_reg.ovf;
        v[LAP_AUD_UNF_BIT]  = audio_reg.unf;
        v[LAP_AUD_CLR_BIT]  = audio_reg.err_rst;
        v[LAP_AUD_EDGE_BIT] = audio_reg.rise_edge;
      end
      LAP_PCLK_OFS: begin
        v[LAP_PCLK_EXT_BIT] = dual_reg.second_port_select ? pclk_copy_reg[1] : pclk_copy_reg[0];
      end
      LAP_DUAL_OFS: begin
        v[LAP_DUAL_LOCK_BIT]                 = dual_reg.lock_mode;
        v[LAP_DUAL_RAW_BIT]                  = dual_reg.raw_bc;
        v[LAP_DUAL_MODE_HI:LAP_DUAL_MODE_LO] = dual_reg.input_mode;
        v[LAP_DUAL_P1_BIT]                   = dual_reg.second_port_select;
        v[LAP_DUAL_P0_BIT]                   = dual_reg.first_port_select;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb rd_data = reg_read(ptr_reg);

  // Control bus slave: first written byte sets the pointer, later bytes auto-increment.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg      <= LAP_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      tx_reg         <= 8'h00;
      ptr_reg        <= 8'h00;
      first_byte_reg <= 1'b0;
      sda_oe         <= 1'b0;
      wr_reg         <= '0;
    end else begin
      wr_reg.wr <= 1'b0;
      if (bus_start) begin
        state_reg      <= LAP_ADDR;
        bit_cnt_reg    <= 4'h0;
        first_byte_reg <= 1'b1;
        sda_oe         <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= LAP_IDLE;
        sda_oe    <= 1'b0;
      end else begin
        unique case (state_reg)
          LAP_IDLE: begin
            sda_oe <= 1'b0;
          end
          LAP_ADDR, LAP_WR_BYTE: begin
            if (scl_rise && bit_cnt_reg != 4'h8) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              if (state_reg == LAP_ADDR) begin
                if (shift_reg[7:1] == LAP_SLAVE_ADDR) begin
                  state_reg <= LAP_ADDR_ACK;
                  tx_reg[0] <= shift_reg[0];
                  sda_oe    <= 1'b1;
                end else begin
                  state_reg <= LAP_IDLE;
                end
              end else begin
                state_reg <= LAP_WR_ACK;
                sda_oe    <= 1'b1;
                if (first_byte_reg) begin
                  ptr_reg        <= shift_reg;
                  first_byte_reg <= 1'b0;
                end else begin
                  wr_reg  <= '{wr: 1'b1, addr: ptr_reg, data: shift_reg};
                  ptr_reg <= ptr_reg + 8'h01;
                end
              end
            end
          end
          LAP_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (tx_reg[0]) begin
                state_reg <= LAP_RD_BYTE;
                tx_reg    <= rd_data;
                sda_oe    <= ~rd_data[7];
                ptr_reg   <= ptr_reg + 8'h01;
              end else begin
                state_reg <= LAP_WR_BYTE;
                sda_oe    <= 1'b0;
              end
            end
          end
          LAP_WR_ACK: begin
            if (scl_fall) begin
              state_reg   <= LAP_WR_BYTE;
              bit_cnt_reg <= 4'h0;
              sda_oe      <= 1'b0;
            end
          end
          LAP_RD_BYTE: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                state_reg <= LAP_RD_ACK;
                sda_oe    <= 1'b0;
              end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
                sda_oe <= ~tx_reg[6];
              end
            end
          end
          LAP_RD_ACK: begin
            if (scl_rise && sda_s) begin
              state_reg <= LAP_IDLE;
            end else if (scl_fall) begin
              state_reg   <= LAP_RD_BYTE;
              bit_cnt_reg <= 4'h0;
              tx_reg      <= rd_data;
              sda_oe      <= ~rd_data[7];
              ptr_reg     <= ptr_reg + 8'h01;
            end
          end
        endcase
      end
    end
  end

  // Open-drain: only ever pulls low.
  assign sda_out = 1'b0;

  assign err_clear = wr_reg.wr && wr_reg.addr == LAP_AUDIO_OFS && wr_reg.data[LAP_AUD_CLR_BIT];

  // A FIFO event in the clearing cycle still lands, so no error goes unseen.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      audio_reg <= lap_audio_t'(LAP_AUDIO_RST[3:0]);
    end else begin
      if (fifo_overflow_evt) begin
        audio_reg.ovf <= 1'b1;
      end else if (err_clear) begin
        audio_reg.ovf <= 1'b0;
      end
      if (fifo_underflow_evt) begin
        audio_reg.unf <= 1'b1;
      end else if (err_clear) begin
        audio_reg.unf <= 1'b0;
      end
      if (wr_reg.wr && wr_reg.addr == LAP_AUDIO_OFS) begin
        audio_reg.err_rst   <= wr_reg.data[LAP_AUD_CLR_BIT];
        audio_reg.rise_edge <= wr_reg.data[LAP_AUD_EDGE_BIT];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pclk_copy_reg <= {2{LAP_PCLK_RST[LAP_PCLK_EXT_BIT]}};
    end else if (wr_reg.wr && wr_reg.addr == LAP_PCLK_OFS) begin
      if (dual_reg.first_port_select) begin
        pclk_copy_reg[0] <= wr_reg.data[LAP_PCLK_EXT_BIT];
      end
      if (dual_reg.second_port_select) begin
        pclk_copy_reg[1] <= wr_reg.data[LAP_PCLK_EXT_BIT];
      end
    end
  end

  // The shared register is written whichever port is selected.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dual_reg <= lap_dual_t'(LAP_DUAL_RST[5:0]);
    end else if (wr_reg.wr && wr_reg.addr == LAP_DUAL_OFS) begin
      dual_reg <= lap_dual_t'({wr_reg.data[LAP_DUAL_LOCK_BIT:LAP_DUAL_MODE_LO],
                               wr_reg.data[LAP_DUAL_P1_BIT:LAP_DUAL_P0_BIT]});
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_lock         <= 1'b0;
      backchannel_out <= 1'b0;
    end else begin
      rx_lock <= dual_reg.lock_mode ? link_valid
                                    : link_valid & ~video_disabled;
      backchannel_out <= dual_reg.raw_bc ? gp0_s : filtered_backchannel;
    end
  end

  assign audio_rising_edge = audio_reg.rise_edge;
  assign pclk_external_sel = pclk_copy_reg;
  assign link_input_mode   = dual_reg.input_mode;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  ovf_set_a: assert property (fifo_overflow_evt |=> audio_reg.ovf)
    else $error("overflow event not recorded");
  unf_set_a: assert property (fifo_underflow_evt |=> audio_reg.unf)
    else $error("underflow event not recorded");
  err_clear_a: assert property (err_clear && !fifo_overflow_evt && !fifo_underflow_evt
                                |=> !audio_reg.ovf && !audio_reg.unf)
    else $error("error flags not cleared");
  flag_hold_a: assert property (!err_clear
                                |=> audio_reg.ovf >= $past(audio_reg.ovf)
                                    && audio_reg.unf >= $past(audio_reg.unf))
    else $error("error flag dropped without clear");
  edge_write_a: assert property (wr_reg.wr && wr_reg.addr == LAP_AUDIO_OFS
                                 |=> audio_rising_edge == $past(wr_reg.data[LAP_AUD_EDGE_BIT]))
    else $error("edge select not written");
  pclk_change_a: assert property ($changed(pclk_external_sel)
                                  |-> $past(wr_reg.wr && wr_reg.addr == LAP_PCLK_OFS))
    else $error("pixel clock select changed without write");
  lock_video_a: assert property (!dual_reg.lock_mode && video_disabled && !wr_reg.wr
                                 |=> !rx_lock)
    else $error("lock shown without active video");
  lock_link_a: assert property (dual_reg.lock_mode && link_valid && !wr_reg.wr |=> rx_lock)
    else $error("lock missing on valid link");
  raw_bc_a: assert property (dual_reg.raw_bc && !wr_reg.wr
                             |=> backchannel_out == $past(gp0_s))
    else $error("raw back channel not passed");
  mode_write_a: assert property (wr_reg.wr && wr_reg.addr == LAP_DUAL_OFS
                                 |=> link_input_mode == $past(wr_reg.data[LAP_DUAL_MODE_HI:LAP_DUAL_MODE_LO]))
    else $error("input mode not written");
  port1_write_a: assert property (wr_reg.wr && wr_reg.addr == LAP_PCLK_OFS && dual_reg.second_port_select
                                  |=> pclk_copy_reg[1] == $past(wr_reg.data[LAP_PCLK_EXT_BIT]))
    else $error("port 1 copy not written");
  port0_write_a: assert property (wr_reg.wr && wr_reg.addr == LAP_PCLK_OFS && dual_reg.first_port_select
                                  |=> pclk_copy_reg[0] == $past(wr_reg.data[LAP_PCLK_EXT_BIT]))
    else $error("port 0 copy not written");
  port_read_a: assert property (ptr_reg == LAP_PCLK_OFS
                                |-> rd_data[LAP_PCLK_EXT_BIT] == pclk_copy_reg[dual_reg.second_port_select])
    else $error("wrong port copy read");
  rsvd_zero_a: assert property (!(ptr_reg == LAP_AUDIO_OFS && rd_data[7:4] != 4'h0)
                                && !(ptr_reg == LAP_PCLK_OFS && rd_data[6:0] != 7'h00))
    else $error("reserved bits not zero");

  err_clear_c: cover property (err_clear ##1 !audio_reg.ovf);
  both_ports_c: cover property (wr_reg.wr && wr_reg.addr == LAP_PCLK_OFS
                                && dual_reg.first_port_select && dual_reg.second_port_select);
  lock_mode_c: cover property (dual_reg.lock_mode && video_disabled ##1 rx_lock);
  read_c: cover property (state_reg == LAP_RD_ACK);

endmodule
`default_nettype wire

/* rtl/lap_pkg.sv */
package lap_pkg;

  // Register offsets on the control bus.
  localparam logic [7:0] LAP_AUDIO_OFS = 8'h2B;
  localparam logic [7:0] LAP_PCLK_OFS  = 8'h2E;
  localparam logic [7:0] LAP_DUAL_OFS  = 8'h34;

  // Seven-bit control bus slave address; the value is arbitrary.
  localparam logic [6:0] LAP_SLAVE_ADDR = 7'h2C;

  // Field positions in audio_serial_control.
  localparam int LAP_AUD_OVF_BIT  = 3;
  localparam int LAP_AUD_UNF_BIT  = 2;
  localparam int LAP_AUD_CLR_BIT  = 1;
  localparam int LAP_AUD_EDGE_BIT = 0;

  // Field positions in pixel_clock_test_mode.
  localparam int LAP_PCLK_EXT_BIT = 7;

  // Field positions in dual_receive_control.
  localparam int LAP_DUAL_LOCK_BIT = 6;
  localparam int LAP_DUAL_RAW_BIT  = 5;
  localparam int LAP_DUAL_MODE_HI  = 4;
  localparam int LAP_DUAL_MODE_LO  = 3;
  localparam int LAP_DUAL_P1_BIT   = 1;
  localparam int LAP_DUAL_P0_BIT   = 0;

  // Reset values.
  localparam logic [7:0] LAP_AUDIO_RST = 8'h00;
  localparam logic [7:0] LAP_PCLK_RST  = 8'h00;
  localparam logic [7:0] LAP_DUAL_RST  = 8'h01;

  // Receiver input modes.
  localparam logic [1:0] LAP_MODE_AUTO   = 2'h0;
  localparam logic [1:0] LAP_MODE_DUAL   = 2'h1;
  localparam logic [1:0] LAP_MODE_SINGLE_PRI = 2'h2;
  localparam logic [1:0] LAP_MODE_SINGLE_SEC = 2'h3;

  typedef struct packed {
    logic ovf;
    logic unf;
    logic err_rst;
    logic rise_edge;
  } lap_audio_t;

  typedef struct packed {
    logic       lock_mode;
    logic       raw_bc;
    logic [1:0] input_mode;
    logic       second_port_select;
    logic       first_port_select;
  } lap_dual_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } lap_wr_t;

  typedef enum logic [2:0] {
    LAP_IDLE,
    LAP_ADDR,
    LAP_ADDR_ACK,
    LAP_WR_BYTE,
    LAP_WR_ACK,
    LAP_RD_BYTE,
    LAP_RD_ACK
  } lap_state_t;

endpackage

/* rtl/lap_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module lap_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  // Only the second stage is visible to the rest of the design.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule
`default_nettype wire

/* verification/lap_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lap_host_model
  import lap_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_low
);
  // Six clocks a phase keeps well above the slave's four-clock minimum after sync.
  localparam int PH = 6;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold();
    repeat (PH) @(posedge core_clk);
    #1;
  endtask

  // Works from idle and as a repeated start from a low clock phase.
  task automatic start_c();
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask

  task automatic stop_c();
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b0;
    hold();
  endtask

  // Data only changes in the low phase, so it never mimics a start or stop.
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    hold();
    scl = 1'b1;
    hold();
    r = sda_line;
    scl = 1'b0;
    hold();
  endtask

  task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(1'b1, a);
    ack = !a;
  endtask

  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] dat, output logic ok);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    logic       a2;
    start_c();
    byte_io({dev, 1'b0}, r, a0);
    byte_io(ofs, r, a1);
    byte_io(dat, r, a2);
    stop_c();
    ok = a0 && a1 && a2;
  endtask

  // Sets the pointer, then reads one byte and ends it with a not-acknowledge.
  task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] dat);
    logic [7:0] r;
    logic       a;
    start_c();
    byte_io({LAP_SLAVE_ADDR, 1'b0}, r, a);
    byte_io(ofs, r, a);
    start_c();
    byte_io({LAP_SLAVE_ADDR, 1'b1}, r, a);
    byte_io(8'hFF, dat, a);
    stop_c();
  endtask
endmodule
`default_nettype wire

/* verification/lap_regs_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module lap_regs_tb_top
  import lap_pkg::*;
;
  logic       core_clk;
  logic       arst_n;
  logic       scl;
  logic       sda_low;
  logic       sda_out;
  logic       sda_oe;
  logic       ovf_evt;
  logic       unf_evt;
  logic       link_valid;
  logic       video_disabled;
  logic       gp_in0;
  logic       filt_bc;
  logic       rise_edge;
  logic       rx_lock;
  logic       bc_out;
  logic [1:0] pclk_sel;
  logic [1:0] in_mode;
  logic       sda_line;
  logic       ok;
  int         fail_count = 0;
  int         cmp_count = 0;
  int         cycles = 0;

  // The data line has a pull-up, so it reads high whenever nobody pulls it.
  assign sda_line = !(sda_low || (sda_oe && !sda_out));

  lap_regs lap_regs_inst (
    .core_clk(core_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .fifo_overflow_evt(ovf_evt),
    .fifo_underflow_evt(unf_evt), .link_valid(link_valid), .video_disabled(video_disabled),
    .local_gp_input0(gp_in0), .filtered_backchannel(filt_bc), .audio_rising_edge(rise_edge),
    .pclk_external_sel(pclk_sel), .rx_lock(rx_lock), .backchannel_out(bc_out),
    .link_input_mode(in_mode)
  );

  lap_host_model lap_host_model_inst (
    .core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Roughly twice the expected run length.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_pin(input string nm, input logic [1:0] exp, input logic [1:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    lap_host_model_inst.rd_reg(ofs, d);
    chk_reg($sformatf("register %h", ofs), exp, d);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
    lap_host_model_inst.wr_reg(LAP_SLAVE_ADDR, ofs, dat, ok);
    chk_pin("ack", 2'h1, {1'b0, ok});
  endtask

  task automatic test_reset();
    chk_pin("edge", 2'h0, {1'b0, rise_edge});
    chk_pin("pclk", 2'h0, pclk_sel);
    chk_pin("mode", 2'h0, in_mode);
    rd_chk(LAP_AUDIO_OFS, 8'h00);
    rd_chk(LAP_PCLK_OFS, 8'h00);
    rd_chk(LAP_DUAL_OFS, 8'h01);
    rd_chk(8'h30, 8'h00);
  endtask

  // Single-cycle events must leave flags that survive until the clear write.
  task automatic test_audio();
    ovf_evt = 1'b1;
    step(1);
    ovf_evt = 1'b0;
    step(5);
    rd_chk(LAP_AUDIO_OFS, 8'h08);
    unf_evt = 1'b1;
    step(1);
    unf_evt = 1'b0;
    rd_chk(LAP_AUDIO_OFS, 8'h0C);
    wr(LAP_AUDIO_OFS, 8'h02);
    rd_chk(LAP_AUDIO_OFS, 8'h02);
    wr(LAP_AUDIO_OFS, 8'hFD);
    rd_chk(LAP_AUDIO_OFS, 8'h01);
    chk_pin("edge", 2'h1, {1'b0, rise_edge});
    wr(LAP_AUDIO_OFS, 8'h00);
    chk_pin("edge", 2'h0, {1'b0, rise_edge});
  endtask

  task automatic test_ports();
    wr(LAP_DUAL_OFS, 8'h02);
    wr(LAP_PCLK_OFS, 8'hFF);
    chk_pin("pclk", 2'h2, pclk_sel);
    rd_chk(LAP_PCLK_OFS, 8'h80);
    wr(LAP_DUAL_OFS, 8'h01);
    rd_chk(LAP_PCLK_OFS, 8'h00);
    wr(LAP_DUAL_OFS, 8'h03);
    wr(LAP_PCLK_OFS, 8'h00);
    chk_pin("pclk", 2'h0, pclk_sel);
    wr(LAP_DUAL_OFS, 8'h01);
    wr(LAP_PCLK_OFS, 8'h80);
    chk_pin("pclk", 2'h1, pclk_sel);
    wr(LAP_DUAL_OFS, 8'h03);
    rd_chk(LAP_PCLK_OFS, 8'h00);
    wr(LAP_DUAL_OFS, 8'hFF);
    rd_chk(LAP_DUAL_OFS, 8'h7B);
  endtask

  task automatic test_mode();
    for (int m = 0; m < 4; m++) begin
      wr(LAP_DUAL_OFS, 8'(m << 3) | 8'h01);
      chk_pin("mode", 2'(m), in_mode);
    end
  endtask

  task automatic test_lock();
    wr(LAP_DUAL_OFS, 8'h01);
    link_valid = 1'b1;
    video_disabled = 1'b1;
    step(3);
    chk_pin("lock", 2'h0, {1'b0, rx_lock});
    video_disabled = 1'b0;
    step(3);
    chk_pin("lock", 2'h1, {1'b0, rx_lock});
    wr(LAP_DUAL_OFS, 8'h41);
    video_disabled = 1'b1;
    step(3);
    chk_pin("lock", 2'h1, {1'b0, rx_lock});
    link_valid = 1'b0;
    step(3);
    chk_pin("lock", 2'h0, {1'b0, rx_lock});
  endtask

  // The raw path runs through a synchroniser, hence the longer waits.
  task automatic test_bc();
    filt_bc = 1'b1;
    step(5);
    chk_pin("backchannel", 2'h1, {1'b0, bc_out});
    wr(LAP_DUAL_OFS, 8'h21);
    filt_bc = 1'b0;
    gp_in0 = 1'b1;
    step(5);
    chk_pin("backchannel", 2'h1, {1'b0, bc_out});
    gp_in0 = 1'b0;
    step(5);
    chk_pin("backchannel", 2'h0, {1'b0, bc_out});
  endtask

  task automatic test_refuse();
    lap_host_model_inst.wr_reg(LAP_SLAVE_ADDR ^ 7'h01, LAP_AUDIO_OFS, 8'h01, ok);
    chk_pin("ack", 2'h0, {1'b0, ok});
    rd_chk(LAP_AUDIO_OFS, 8'h00);
  endtask

  initial begin
    arst_n = 1'b0;
    ovf_evt = 1'b0;
    unf_evt = 1'b0;
    link_valid = 1'b0;
    video_disabled = 1'b0;
    gp_in0 = 1'b0;
    filt_bc = 1'b0;
    step(3);
    arst_n = 1'b1;
    step(3);
    test_reset();
    test_audio();
    test_ports();
    test_mode();
    test_lock();
    test_bc();
    test_refuse();
    final_report();
  end
endmodule
`default_nettype wire
